// >>> shared/bil_loader_cfg.svh
// Constants of the boot image loader: field positions, fixed values, timing.
// Assumes a 250 MHz tile clock; included by bare name.
`ifndef BIL_LOADER_CFG_SVH
`define BIL_LOADER_CFG_SVH

// ==========================================================================
// Security word and image format
`define BIL_SEC_OTP_BIT 5
`define BIL_CRC_POLY 32'hEDB8_8320
`define BIL_CRC_INIT 32'hFFFF_FFFF
`define BIL_CRC_SKIP 32'h0D15_AB1E
`define BIL_OTP_START 32'h0000_0000
`define BIL_RAM_START 32'h0000_0000

// ==========================================================================
// Flash access: quad-output read, 24-bit address, 8 dummy clocks
`define BIL_FLASH_CMD 8'h6B
`define BIL_FLASH_ADDR_BITS 24
`define BIL_FLASH_DUMMY 8

// ==========================================================================
// Timing
`define BIL_CLK_PERIOD_NS 4
`define BIL_RST_DELAY_NS 15000
`define BIL_RST_DELAY_CYC ((`BIL_RST_DELAY_NS + `BIL_CLK_PERIOD_NS - 1) / `BIL_CLK_PERIOD_NS)

`endif

// >>> shared/bil_loader_pkg.sv
// Types of the boot image loader: sequencer states and flash pin group.
// Assumes bil_loader_cfg.svh holds the numeric constants.
package bil_loader_pkg;

    // ======================================================================
    // Sequencer states, one-hot
    typedef enum logic [9:0] {
        BIL_ST_HOLD   = 10'b00_0000_0001,
        BIL_ST_DELAY  = 10'b00_0000_0010,
        BIL_ST_SEL    = 10'b00_0000_0100,
        BIL_ST_LEN    = 10'b00_0000_1000,
        BIL_ST_PROG   = 10'b00_0001_0000,
        BIL_ST_CHK    = 10'b00_0010_0000,
        BIL_ST_VERIFY = 10'b00_0100_0000,
        BIL_ST_RUN    = 10'b00_1000_0000,
        BIL_ST_FAIL   = 10'b01_0000_0000,
        BIL_ST_SPARE  = 10'b10_0000_0000
    } bil_state_e;

    // ======================================================================
    // Flash pins driven through the tile 0 ports
    typedef struct packed {
        logic       sclk;
        logic       cs_n;
        logic [3:0] dq_o;
        logic [3:0] dq_oe;
    } bil_qspi_s;

endpackage

// >>> rtl/bil_loader.sv
// Boot image loader: reset sequencing, source select, image copy, CRC check.
// Assumes all inputs synchronous to clk; flash presents data while sclk low.
// Operation
// - Stay in reset while the external active-low reset pin is low.
// - Enable pull-downs on all general-purpose pins while in reset.
// - After reset release wait the internal delay, then start booting.
// - Security bit 5 set selects OTP as source, else internal flash.
// - Default source is the embedded quad-SPI flash over the serial interface.
// - Flash pins are driven through the tile 0 port group.
// - Read 32-bit length word s, then exactly s times four bytes.
// - Then read a 32-bit check word; the skip value bypasses CRC checking.
// - Length and check words arrive least significant byte first.
// - Program bytes go to RAM from address zero upward in order.
// - After loading, execution starts at the lowest RAM address.
// - CRC covers length word bytes and program bytes, not check word.
// - CRC uses reflected polynomial 0xEDB88320, bytes taken LSB first.
// - CRC register is preset to all ones before the first byte.
// - Final CRC is the inverted register, compared with the check word.
// - OTP boot skips the boot ROM and reads from OTP address zero.
// - OTP image contents are copied to SRAM and run before anything else.
`timescale 1ns/1ps
`include "bil_loader_cfg.svh"

module bil_loader
    import bil_loader_pkg::*;
#(
    parameter int RAM_AW = 17,
    parameter int OTP_AW = 11
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic rst_pin_n,
    input wire logic [31:0] sec_reg,
    input wire logic [3:0] qspi_dq_i,
    output bil_qspi_s qspi,
    output logic otp_rd,
    output logic [OTP_AW-1:0] otp_addr,
    input wire logic [31:0] otp_rdata,
    input wire logic otp_rvalid,
    output logic ram_we,
    output logic [RAM_AW-1:0] ram_addr,
    output logic [7:0] ram_wdata,
    output logic gpio_pd_en,
    output logic core_run,
    output logic [31:0] core_pc,
    output logic boot_fail,
    output logic boot_busy
);
    // ======================================================================
    // Elaboration checks
    initial
    begin
        if (RAM_AW < 3 || RAM_AW > 32 || OTP_AW < 1 || OTP_AW > 30)
            $error("RAM_AW or OTP_AW out of range");
    end
    localparam int DLY_W = 12;
    localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(`BIL_RST_DELAY_CYC - 1);
    localparam logic [33:0] RAM_BYTES = 34'(1) << RAM_AW;
    localparam logic [5:0] FL_HDR = 6'(8 + `BIL_FLASH_ADDR_BITS);
    localparam logic [5:0] FL_DATA = 6'(8 + `BIL_FLASH_ADDR_BITS + `BIL_FLASH_DUMMY);
    // ======================================================================
    // CRC byte step, reflected, LSB first
    function automatic logic [31:0] bil_crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h00_0000, b};
        for (int i = 0; i < 8; i++)
            r = r[0] ? ((r >> 1) ^ `BIL_CRC_POLY) : (r >> 1);
        return r;
    endfunction
    bil_state_e state;
    logic [DLY_W-1:0] dly_cnt;
    logic [31:0] crc, len, chk, fl_tx, ow;
    logic otp_mode, fl_ph, fl_half, fl_bv, otp_pend, ow_full, first_wr;
    logic [1:0] bcnt, ow_idx;
    logic [33:0] pcnt;
    logic [5:0] fl_cnt;
    logic [3:0] fl_hi;
    logic [7:0] fl_byte;
    // ======================================================================
    // Decode
    wire in_rst = sys_rst | ~rst_pin_n;
    wire streaming = (state == BIL_ST_LEN) | (state == BIL_ST_PROG) | (state == BIL_ST_CHK);
    wire fl_active = streaming & ~otp_mode;
    wire ot_active = streaming & otp_mode;
    wire s_valid = otp_mode ? ow_full : fl_bv;
    wire [7:0] s_byte = otp_mode ? ow[{ow_idx, 3'b000} +: 8] : fl_byte;
    wire [31:0] next_len = {s_byte, len[31:8]};
    wire [31:0] next_chk = {s_byte, chk[31:8]};
    wire [31:0] next_crc = bil_crc_byte(crc, s_byte);
    wire [33:0] prog_bytes = {len, 2'b00};
    wire len_last = s_valid & (bcnt == 2'd3);
    wire prog_last = s_valid & (pcnt == prog_bytes - 34'd1);
    wire len_too_big = {next_len, 2'b00} > RAM_BYTES;
    wire crc_ok = (chk == `BIL_CRC_SKIP) | (~crc == chk);

    // ======================================================================
    // Sequencer
    always_ff @(posedge clk)
    begin
        if (in_rst)
        begin
            state <= BIL_ST_HOLD;
            dly_cnt <= '0;
            otp_mode <= 1'b0;
            crc <= `BIL_CRC_INIT;
            len <= '0;
            chk <= '0;
            bcnt <= '0;
            pcnt <= '0;
            gpio_pd_en <= 1'b1;
            core_run <= 1'b0;
            core_pc <= `BIL_RAM_START;
            boot_fail <= 1'b0;
            boot_busy <= 1'b0;
        end
        else
        begin
            gpio_pd_en <= 1'b0;
            case (state)
                BIL_ST_HOLD:
                begin
                    boot_busy <= 1'b1;
                    state <= BIL_ST_DELAY;
                end
                BIL_ST_DELAY:
                begin
                    dly_cnt <= dly_cnt + 1'b1;
                    if (dly_cnt == DLY_LAST)
                        state <= BIL_ST_SEL;
                end
                BIL_ST_SEL:
                begin
                    otp_mode <= sec_reg[`BIL_SEC_OTP_BIT];
                    crc <= `BIL_CRC_INIT;
                    bcnt <= '0;
                    state <= BIL_ST_LEN;
                end
                BIL_ST_LEN:
                begin
                    if (s_valid)
                    begin
                        len <= next_len;
                        crc <= next_crc;
                        bcnt <= bcnt + 1'b1;
                    end
                    // Oversized image would wrap over itself in RAM
                    if (len_last && len_too_big)
                        state <= BIL_ST_FAIL;
                    else if (len_last)
                        state <= (next_len == '0) ? BIL_ST_CHK : BIL_ST_PROG;
                end
                BIL_ST_PROG:
                begin
                    if (s_valid)
                    begin
                        crc <= next_crc;
                        pcnt <= pcnt + 34'd1;
                    end
                    if (prog_last)
                        state <= BIL_ST_CHK;
                end
                BIL_ST_CHK:
                begin
                    if (s_valid)
                    begin
                        chk <= next_chk;
                        bcnt <= bcnt + 1'b1;
                    end
                    if (len_last)
                        state <= BIL_ST_VERIFY;
                end
                BIL_ST_VERIFY:
                    state <= crc_ok ? BIL_ST_RUN : BIL_ST_FAIL;
                BIL_ST_RUN:
                begin
                    core_run <= 1'b1;
                    core_pc <= `BIL_RAM_START;
                    boot_busy <= 1'b0;
                end
                BIL_ST_FAIL:
                begin
                    boot_fail <= 1'b1;
                    boot_busy <= 1'b0;
                end
                default:
                    state <= BIL_ST_FAIL;
            endcase
        end
    end
    // ======================================================================
    // RAM write port
    always_ff @(posedge clk)
    begin
        if (in_rst)
        begin
            ram_we <= 1'b0;
            ram_addr <= '0;
            ram_wdata <= '0;
            first_wr <= 1'b1;
        end
        else
        begin
            ram_we <= (state == BIL_ST_PROG) & s_valid;
            if ((state == BIL_ST_PROG) && s_valid)
            begin
                ram_addr <= pcnt[RAM_AW-1:0];
                ram_wdata <= s_byte;
            end
            if (ram_we)
                first_wr <= 1'b0;
        end
    end
    // ======================================================================
    // Flash engine: one sclk period is two clk cycles
    always_ff @(posedge clk)
    begin
        if (in_rst)
        begin
            qspi <= '{sclk: 1'b0, cs_n: 1'b1, dq_o: 4'h0, dq_oe: 4'h0};
            fl_ph <= 1'b0;
            fl_cnt <= '0;
            fl_tx <= {`BIL_FLASH_CMD, 24'h00_0000};
            fl_hi <= '0;
            fl_half <= 1'b0;
            fl_bv <= 1'b0;
            fl_byte <= '0;
        end
        else
        begin
            fl_bv <= 1'b0;
            if (fl_active)
            begin
                qspi.cs_n <= 1'b0;
                fl_ph <= ~fl_ph;
                if (!fl_ph)
                begin
                    qspi.sclk <= 1'b0;
                    qspi.dq_o <= {3'b000, fl_tx[31]};
                    qspi.dq_oe <= (fl_cnt < FL_HDR) ? 4'b0001 : 4'b0000;
                end
                else
                begin
                    qspi.sclk <= 1'b1;
                    if (fl_cnt < FL_HDR)
                        fl_tx <= {fl_tx[30:0], 1'b0};
                    if (fl_cnt < FL_DATA)
                        fl_cnt <= fl_cnt + 6'd1;
                    else
                    begin
                        // High nibble first on the wire
                        fl_half <= ~fl_half;
                        fl_hi <= qspi_dq_i;
                        if (fl_half)
                        begin
                            fl_byte <= {fl_hi, qspi_dq_i};
                            fl_bv <= 1'b1;
                        end
                    end
                end
            end
            else
            begin
                qspi <= '{sclk: 1'b0, cs_n: 1'b1, dq_o: 4'h0, dq_oe: 4'h0};
                fl_ph <= 1'b0;
            end
        end
    end
    // ======================================================================
    // OTP engine: word reads from address zero, bytes out LSB first
    always_ff @(posedge clk)
    begin
        if (in_rst)
        begin
            otp_rd <= 1'b0;
            otp_addr <= OTP_AW'(`BIL_OTP_START);
            otp_pend <= 1'b0;
            ow_full <= 1'b0;
            ow <= '0;
            ow_idx <= '0;
        end
        else
        begin
            otp_rd <= 1'b0;
            if (ot_active && !ow_full && !otp_pend)
            begin
                otp_rd <= 1'b1;
                otp_pend <= 1'b1;
            end
            if (otp_pend && otp_rvalid)
            begin
                ow <= otp_rdata;
                ow_full <= 1'b1;
                otp_pend <= 1'b0;
                otp_addr <= otp_addr + 1'b1;
            end
            // One-word prefetch only; OTP latency sets the copy rate
            if (ow_full)
            begin
                ow_idx <= ow_idx + 1'b1;
                if (ow_idx == 2'd3)
                    ow_full <= 1'b0;
            end
        end
    end
    // ======================================================================
    // Checks
    hold_reset_a: assert property (@(posedge clk) in_rst |=> state == BIL_ST_HOLD)
        else $error("left reset state while reset held");
    reset_pulldown_a: assert property (@(posedge clk) in_rst |=> gpio_pd_en)
        else $error("pull-downs off during reset");
    delay_wait_a: assert property (@(posedge clk) disable iff (in_rst)
        (state == BIL_ST_DELAY && dly_cnt != DLY_LAST) |=> state == BIL_ST_DELAY)
        else $error("boot began before delay elapsed");
    src_select_a: assert property (@(posedge clk) disable iff (in_rst)
        state == BIL_ST_SEL |=> otp_mode == $past(sec_reg[`BIL_SEC_OTP_BIT]))
        else $error("wrong boot source");
    crc_preset_a: assert property (@(posedge clk) disable iff (in_rst)
        state == BIL_ST_SEL |=> crc == `BIL_CRC_INIT)
        else $error("crc not preset");
    cs_hold_a: assert property (@(posedge clk) disable iff (in_rst)
        (fl_active && $past(fl_active)) |-> !qspi.cs_n)
        else $error("chip select dropped mid image");
    first_write_a: assert property (@(posedge clk) disable iff (in_rst)
        (ram_we && first_wr) |-> ram_addr == '0)
        else $error("first byte not at RAM base");
    skip_crc_a: assert property (@(posedge clk) disable iff (in_rst)
        (state == BIL_ST_VERIFY && chk == `BIL_CRC_SKIP) |=> ##1 core_run)
        else $error("skip value did not start program");
    crc_fail_a: assert property (@(posedge clk) disable iff (in_rst)
        (state == BIL_ST_VERIFY && !crc_ok) |=> ##1 (boot_fail && !core_run))
        else $error("mismatch not flagged");
    run_addr_a: assert property (@(posedge clk) disable iff (in_rst)
        core_run |-> core_pc == `BIL_RAM_START && !boot_fail)
        else $error("start address not RAM base");
endmodule

// >>> tb/bil_flash_model.sv
// Behavioural model of the embedded quad flash behind the loader.
// Assumes the image bytes are loaded into img by the bench before boot.
`timescale 1ns/1ps

module bil_flash_model
    import bil_loader_pkg::*;
(
    input wire logic clk,
    input bil_qspi_s qspi,
    output logic [3:0] dq
);
    // ======================================================================
    // Image store and header capture
    logic [7:0] img [0:63];
    logic [31:0] hdr = 32'h0000_0000;
    int rises = 0;
    logic sclk_q = 1'b0;
    logic tog = 1'b0;
    int idx;
    logic [7:0] cur;

    always @(posedge clk)
    begin
        tog <= ~tog;
        sclk_q <= qspi.sclk;
        if (qspi.cs_n)
            rises <= 0;
        else if (qspi.sclk && !sclk_q)
        begin
            rises <= rises + 1;
            if (rises < 32)
                hdr <= {hdr[30:0], qspi.dq_o[0]};
        end
    end

    // ======================================================================
    // Data after command, address and dummy clocks; high nibble first
    assign idx = rises - 40;
    assign cur = img[idx >> 1];
    // Deselected or not yet in data phase: toggle so stale bits never match
    assign dq = (qspi.cs_n || rises < 40) ? {4{tog}} ^ 4'hA
              : (idx[0] ? cur[3:0] : cur[7:4]);
endmodule

// >>> tb/tb.sv
// Self-checking bench for the boot image loader, flash and OTP boots.
// Assumes the flash model file and the design sources are compiled first.
`timescale 1ns/1ps
`include "bil_loader_cfg.svh"

module tb
    import bil_loader_pkg::*;
;
    // ======================================================================
    // Stimulus and monitors
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic rst_pin_n = 1'b0;
    logic [31:0] sec_reg = 32'h0000_0000;
    logic [3:0] dq;
    bil_qspi_s qspi;
    logic otp_rd;
    logic [10:0] otp_addr;
    logic [31:0] otp_rdata = 32'h0000_0000;
    logic otp_rvalid = 1'b0;
    logic ram_we;
    logic [16:0] ram_addr;
    logic [7:0] ram_wdata;
    logic gpio_pd_en, core_run, boot_fail, boot_busy;
    logic [31:0] core_pc;
    int error_cnt = 0;
    int num_checks = 0;
    logic [31:0] wr_q [$];
    logic cs_seen, otp_seen;
    logic [10:0] otp_first;
    int pend = 0;
    int pa = 0;

    always #2 clk = ~clk;

    bil_loader uut (.clk(clk), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n), .sec_reg(sec_reg),
        .qspi_dq_i(dq), .qspi(qspi), .otp_rd(otp_rd), .otp_addr(otp_addr),
        .otp_rdata(otp_rdata), .otp_rvalid(otp_rvalid), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata), .gpio_pd_en(gpio_pd_en),
        .core_run(core_run), .core_pc(core_pc), .boot_fail(boot_fail),
        .boot_busy(boot_busy));

    bil_flash_model flash (.clk(clk), .qspi(qspi), .dq(dq));

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            wr_q.delete();
            cs_seen <= 1'b0;
            otp_seen <= 1'b0;
        end
        else
        begin
            if (ram_we)
                wr_q.push_back({7'h00, ram_addr, ram_wdata});
            if (!qspi.cs_n)
                cs_seen <= 1'b1;
            if (otp_rd && !otp_seen)
            begin
                otp_seen <= 1'b1;
                otp_first <= otp_addr;
            end
        end
    end

    // OTP answers four cycles after each request; data toggles otherwise
    always @(posedge clk)
    begin
        otp_rvalid <= 1'b0;
        otp_rdata <= ~otp_rdata;
        if (pend != 0)
            pend <= pend - 1;
        if (otp_rd)
        begin
            pend <= 3;
            pa <= int'(otp_addr);
        end
        if (pend == 1)
        begin
            otp_rvalid <= 1'b1;
            otp_rdata <= {flash.img[4*pa+3], flash.img[4*pa+2], flash.img[4*pa+1],
                flash.img[4*pa]};
        end
    end

    // ======================================================================
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h00_0000, b};
        for (int k = 0; k < 8; k++)
            r = r[0] ? ((r >> 1) ^ `BIL_CRC_POLY) : (r >> 1);
        return r;
    endfunction

    // ======================================================================
    // One boot: mode 0 good CRC, 1 skip value, 2 corrupted CRC, 3 oversized length
    task automatic run_boot(input logic otp, input int s, input int mode);
        logic [31:0] crc;
        logic [31:0] chk;
        int n;
        int nb;
        nb = (mode == 3) ? 0 : 4 * s;
        crc = `BIL_CRC_INIT;
        for (int i = 0; i < 4; i++)
            flash.img[i] = 8'(s >> (8 * i));
        for (int i = 0; i < nb; i++)
            flash.img[4+i] = 8'(i * 37 + 5);
        for (int i = 0; i < 4 + nb; i++)
            crc = crc_upd(crc, flash.img[i]);
        chk = (mode == 1) ? `BIL_CRC_SKIP : (~crc ^ ((mode == 2) ? 32'h0000_0001 : 32'h0));
        for (int i = 0; i < 4; i++)
            flash.img[4+nb+i] = chk[8*i +: 8];
        @(posedge clk);
        sys_rst <= 1'b1;
        rst_pin_n <= 1'b0;
        // Other security bits set to show only bit 5 steers the source
        sec_reg <= 32'hFFFF_FFDF | (32'(otp) << `BIL_SEC_OTP_BIT);
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        check(32'(gpio_pd_en), 32'h1, "pull-down in reset");
        check(32'(boot_busy), 32'h0, "busy while pin low");
        check(32'(qspi.cs_n), 32'h1, "select while pin low");
        @(posedge clk);
        rst_pin_n <= 1'b1;
        repeat (2) @(negedge clk);
        check(32'(gpio_pd_en), 32'h0, "pull-down after reset");
        n = 2;
        while (qspi.cs_n === 1'b1 && otp_rd !== 1'b1 && n < 40000)
        begin
            @(negedge clk);
            n++;
        end
        check(32'(n >= 3750 && n <= 37500), 32'h1, "boot start delay");
        check(32'(boot_busy), 32'h1, "busy while loading");
        if (!otp)
            check(32'(qspi.dq_oe), 32'h1, "command lane enable");
        n = 0;
        while (core_run !== 1'b1 && boot_fail !== 1'b1 && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 5000)
        begin
            check(32'h0, 32'h1, "boot never finished");
            return;
        end
        repeat (2) @(negedge clk);
        check(32'(core_run), 32'(mode < 2), "program started");
        check(32'(boot_fail), 32'(mode >= 2), "failure flag");
        check(32'(boot_busy), 32'h0, "busy after boot");
        check(core_pc, `BIL_RAM_START, "start address");
        check(32'(wr_q.size()), 32'(nb), "program byte count");
        for (int i = 0; i < nb && i < wr_q.size(); i++)
            check(wr_q[i], {7'h00, 17'(i), flash.img[4+i]}, "ram write");
        check(32'(cs_seen), 32'(!otp), "flash selected");
        if (otp)
            check(32'(otp_first), `BIL_OTP_START, "first otp word");
        else
            check(flash.hdr, {`BIL_FLASH_CMD, 24'h00_0000}, "flash command");
        $display("test done: otp %0d words %0d mode %0d", otp, s, mode);
    endtask

    // ======================================================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        run_boot(1'b0, 3, 0);
        run_boot(1'b0, 0, 1);
        run_boot(1'b0, 2, 2);
        run_boot(1'b1, 2, 0);
        run_boot(1'b1, 1, 2);
        run_boot(1'b0, 32'h0000_8001, 3);
        wrap_up();
    end
endmodule
